// File: src/nidrm_pkg.sv
// package: register map, field layout and reset values of the id/rom-map block
package nidrm_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] UNIQUE_ID_UPPER_OFS       = 8'h24;
  localparam logic [7:0] UNIQUE_ID_LOWER_OFS       = 8'h28;
  localparam logic [7:0] ROM_MAP_BASE_OFS          = 8'h34;
  localparam logic [7:0] WRITE_ERROR_ADDR_LOW_OFS  = 8'h38;
  localparam logic [7:0] WRITE_ERROR_ADDR_HIGH_OFS = 8'h3c;
  localparam logic [7:0] IRQ_STATUS_OFS            = 8'h60;
  localparam logic [7:0] IRQ_MASK_OFS              = 8'h64;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int          ROM_MAP_LSB        = 10;
  localparam logic [31:0] ROM_MAP_FIELD_MASK = 32'hffff_fc00;
  localparam logic [31:0] UNIQUE_ID_RESET    = 32'h0000_0000;
  localparam logic [31:0] ROM_MAP_RESET      = 32'h0000_0000;
  localparam logic [47:0] ROM_SPACE_FIRST    = 48'hffff_f000_0400;
  localparam logic [47:0] ROM_SPACE_LAST     = 48'hffff_f000_07ff;
  localparam int          IRQ_BITS           = 2;
  localparam int          IRQ_ID_LOADED      = 0;
  localparam int          IRQ_WRITE_ERROR    = 1;
  localparam logic [1:0]  AXI_OKAY           = 2'b00;
  localparam logic [1:0]  AXI_SLVERR         = 2'b10;

  // serial rom loader states
  typedef enum logic [1:0] {
    NIDRM_IDLE = 2'b00,
    NIDRM_WAIT = 2'b01,
    NIDRM_DONE = 2'b10
  } nidrm_load_t;

endpackage : nidrm_pkg

// File: src/nidrm_regs.sv
// file: node identifier, rom mapping and write-error register bank
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RQ1) A hardware reset clears the upper identifier word to zero, an invalid id.
// (RQ2) After a bus reset with a serial rom present, both id words load from it.
// (RQ3) Once loaded from the rom, the id words are frozen until the next hardware reset.
// (RQ4) The upper id word carries the maker field and upper silicon serial.
// (RQ5) The lower id word at 28h resets to zero and loads and locks likewise.
// (RQ6) A rom-space quadlet read maps to base plus the low ten offset bits.
// (RQ7) Map register bits 31..10 are writable; bits 9..0 read zero.
// (RQ8) A failed posted write records its low 32 offset bits at 38h.
// (RQ9) The high error word holds requester node in 31..16, offset top in 15..0.
// (RQ10) The map register sits at 34h and resets to zero.
// (RQ11) Software writes to the error words are ignored; only hardware sets them.
// (RQ12) Without a serial rom after bus reset the id words stay zero.
module nidrm_regs
  import nidrm_pkg::*;
(
  input  wire logic        core_clk,        // system clock, 250 MHz
  input  wire logic        rst_n,           // hardware reset, active low
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // byte enables
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  // serial rom loader side
  input  wire logic        bus_reset_pulse, // one-cycle pci reset event
  input  wire logic        rom_present,     // serial rom detected
  output logic             rom_load_req,    // request id fetch from rom
  input  wire logic        rom_load_valid,  // one-cycle: id words ready
  input  wire logic [31:0] rom_id_upper,    // fetched upper id word
  input  wire logic [31:0] rom_id_lower,    // fetched lower id word
  // incoming rom-space read mapping
  input  wire logic        rom_rd_valid,    // quadlet read request pulse
  input  wire logic [47:0] rom_rd_offset,   // 1394 destination offset
  output logic             host_rd_valid,   // mapped host read pulse
  output logic [31:0]      host_rd_addr,    // mapped host memory address
  // posted write failure capture
  input  wire logic        pw_error,        // one-cycle failure pulse
  input  wire logic [47:0] pw_offset,       // offset of failed write
  input  wire logic [15:0] pw_source,       // bus and node of requester
  // status
  output logic             id_locked,       // id words loaded and frozen
  output logic             irq              // level interrupt
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [31:0]         unique_id_upper;
  logic [31:0]         unique_id_lower;
  logic [31:0]         rom_map_base;
  logic [31:0]         write_error_addr_low;
  logic [31:0]         write_error_addr_high;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  nidrm_load_t         load_state;
  nidrm_load_t         next_load_state;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] nidrm_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : nidrm_merge

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;

  // address and data may arrive in either order; each is held until both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // capture of address and data beats
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses get slverr
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == UNIQUE_ID_UPPER_OFS || aw_addr == UNIQUE_ID_LOWER_OFS
          || aw_addr == ROM_MAP_BASE_OFS
          || aw_addr == WRITE_ERROR_ADDR_LOW_OFS
          || aw_addr == WRITE_ERROR_ADDR_HIGH_OFS
          || aw_addr == IRQ_STATUS_OFS || aw_addr == IRQ_MASK_OFS) begin
        s_axi_bresp <= AXI_OKAY;
      end else begin
        s_axi_bresp <= AXI_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // rom mapping base register
  // ----------------------------------------------------------------------
  // (RQ10) map register at 34h
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_map_base <= ROM_MAP_RESET;
    end else if (wr_fire && aw_addr == ROM_MAP_BASE_OFS) begin
      // (RQ7) low ten bits held at zero
      rom_map_base <= nidrm_merge(rom_map_base, w_data, w_strb)
                      & ROM_MAP_FIELD_MASK;
    end
  end

  // (RQ6) rom-space read remap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rd_valid <= 1'b0;
      host_rd_addr  <= 32'h0000_0000;
    end else begin
      host_rd_valid <= rom_rd_valid && rom_rd_offset >= ROM_SPACE_FIRST
                       && rom_rd_offset <= ROM_SPACE_LAST;
      // base has zero low bits, so the sum is a plain concatenation
      host_rd_addr  <= {rom_map_base[31:ROM_MAP_LSB],
                        rom_rd_offset[ROM_MAP_LSB-1:0]};
    end
  end

  // ----------------------------------------------------------------------
  // unique identifier load and lock
  // ----------------------------------------------------------------------
  // loader sequencing
  always_comb begin
    next_load_state = load_state;
    case (load_state)
      NIDRM_IDLE: begin
        // (RQ12) no rom: stay idle, ids stay zero
        if (bus_reset_pulse && rom_present) begin
          next_load_state = NIDRM_WAIT;
        end
      end
      NIDRM_WAIT: begin
        if (rom_load_valid) begin
          next_load_state = NIDRM_DONE;
        end
      end
      NIDRM_DONE: begin
        next_load_state = NIDRM_DONE;
      end
      default: begin
        next_load_state = NIDRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_state <= NIDRM_IDLE;
    end else begin
      load_state <= next_load_state;
    end
  end

  assign rom_load_req = (load_state == NIDRM_WAIT);
  assign id_locked    = (load_state == NIDRM_DONE);

  // (RQ1) zero on hardware reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unique_id_upper <= UNIQUE_ID_RESET;
      unique_id_lower <= UNIQUE_ID_RESET;
    end else if (load_state == NIDRM_WAIT && rom_load_valid) begin
      // (RQ2) fill from serial rom
      // (RQ4) upper word: maker and serial top
      // (RQ5) lower word loads the same way
      unique_id_upper <= rom_id_upper;
      unique_id_lower <= rom_id_lower;
    end
    // (RQ3) frozen after load: no other path writes the id words
  end

  // ----------------------------------------------------------------------
  // posted write error capture
  // ----------------------------------------------------------------------
  // no reset: contents stay undefined until the first failure
  always_ff @(posedge core_clk) begin
    if (pw_error) begin
      // (RQ8) low offset word
      write_error_addr_low  <= pw_offset[31:0];
      // (RQ9) requester node and offset top
      write_error_addr_high <= {pw_source, pw_offset[47:32]};
    end
    // (RQ11) bus writes never reach these
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  logic [IRQ_BITS-1:0] irq_events;
  assign irq_events[IRQ_ID_LOADED]   = load_state == NIDRM_WAIT
                                       && rom_load_valid;
  assign irq_events[IRQ_WRITE_ERROR] = pw_error;

  // write-one-to-clear; a new event wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (wr_fire && aw_addr == IRQ_STATUS_OFS && w_strb[0]) begin
      irq_status <= (irq_status & ~w_data[IRQ_BITS-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= '0;
    end else if (wr_fire && aw_addr == IRQ_MASK_OFS && w_strb[0]) begin
      irq_mask <= w_data[IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // one-cycle read answer from the decoded register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      if (s_axi_araddr == UNIQUE_ID_UPPER_OFS) begin
        s_axi_rdata <= unique_id_upper;
      end else if (s_axi_araddr == UNIQUE_ID_LOWER_OFS) begin
        s_axi_rdata <= unique_id_lower;
      end else if (s_axi_araddr == ROM_MAP_BASE_OFS) begin
        s_axi_rdata <= rom_map_base;
      end else if (s_axi_araddr == WRITE_ERROR_ADDR_LOW_OFS) begin
        s_axi_rdata <= write_error_addr_low;
      end else if (s_axi_araddr == WRITE_ERROR_ADDR_HIGH_OFS) begin
        s_axi_rdata <= write_error_addr_high;
      end else if (s_axi_araddr == IRQ_STATUS_OFS) begin
        s_axi_rdata <= {30'h0000_0000, irq_status};
      end else if (s_axi_araddr == IRQ_MASK_OFS) begin
        s_axi_rdata <= {30'h0000_0000, irq_mask};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= AXI_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_id_reset_zero: assert property ( // (RQ1)
    @(posedge core_clk) disable iff (!rst_n)
    load_state == NIDRM_IDLE |-> unique_id_upper == UNIQUE_ID_RESET)
    else $error("upper id not zero before load");
  a_id_rom_load: assert property ( // (RQ2)
    @(posedge core_clk) disable iff (!rst_n)
    load_state == NIDRM_WAIT && rom_load_valid |=>
    unique_id_upper == $past(rom_id_upper) && id_locked)
    else $error("upper id not loaded from rom");
  a_id_frozen: assert property ( // (RQ3)
    @(posedge core_clk) disable iff (!rst_n)
    id_locked |=> $stable(unique_id_upper) && $stable(unique_id_lower))
    else $error("id changed after lock");

  a_id_lower_load: assert property ( // (RQ5)
    @(posedge core_clk) disable iff (!rst_n)
    load_state == NIDRM_WAIT && rom_load_valid |=>
    unique_id_lower == $past(rom_id_lower))
    else $error("lower id not loaded from rom");

  a_no_rom_idle: assert property ( // (RQ12)
    @(posedge core_clk) disable iff (!rst_n)
    load_state == NIDRM_IDLE && !(bus_reset_pulse && rom_present)
    |=> load_state == NIDRM_IDLE && unique_id_lower == 32'h0000_0000)
    else $error("id left zero state without rom");
  a_map_addr: assert property ( // (RQ6)
    @(posedge core_clk) disable iff (!rst_n)
    rom_rd_valid && rom_rd_offset[47:10] == ROM_SPACE_FIRST[47:10] |=>
    host_rd_valid && host_rd_addr ==
    $past(rom_map_base) + {22'h00_0000, $past(rom_rd_offset[9:0])})
    else $error("rom read mapped wrongly");
  a_map_low_zero: assert property ( // (RQ7)
    @(posedge core_clk) disable iff (!rst_n)
    rom_map_base[9:0] == 10'h000)
    else $error("map reserved bits not zero");

  a_err_low_cap: assert property ( // (RQ8)
    @(posedge core_clk) disable iff (!rst_n)
    pw_error |=> write_error_addr_low == $past(pw_offset[31:0]))
    else $error("error low word not captured");

  a_err_high_cap: assert property ( // (RQ9)
    @(posedge core_clk) disable iff (!rst_n)
    pw_error |=> write_error_addr_high[31:16] == $past(pw_source)
    && write_error_addr_high[15:0] == $past(pw_offset[47:32]))
    else $error("error high word not captured");

  // the status bit proves a capture since reset, so the words are defined
  a_err_no_sw: assert property ( // (RQ11)
    @(posedge core_clk) disable iff (!rst_n)
    irq_status[IRQ_WRITE_ERROR] && !pw_error |=>
    $stable(write_error_addr_low) && $stable(write_error_addr_high))
    else $error("error word changed without failure");

endmodule : nidrm_regs

`default_nettype wire

// File: sim/nidrm_rom_model.sv
// partner model: serial rom that answers an id fetch after a set delay
`timescale 1ns/1ps
`default_nettype none
module nidrm_rom_model (
  input  wire logic        core_clk,       // system clock
  input  wire logic        rst_n,          // reset, active low
  input  wire logic        rom_load_req,   // fetch request from the bank
  input  wire logic [3:0]  delay_cyc,      // answer delay in cycles
  input  wire logic [31:0] word_upper,     // rom contents, upper word
  input  wire logic [31:0] word_lower,     // rom contents, lower word
  output logic             rom_load_valid, // one-cycle answer strobe
  output logic [31:0]      rom_id_upper,   // fetched upper word
  output logic [31:0]      rom_id_lower    // fetched lower word
);
  logic [3:0] wait_cnt;

  // ------------------------------------------------------------------
  // answer logic
  // ------------------------------------------------------------------
  // deliver whole id words
  // data lines toggle outside the strobe so a stale word never passes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt       <= 4'h0;
      rom_load_valid <= 1'b0;
      rom_id_upper   <= 32'h0;
      rom_id_lower   <= 32'h0;
    end else if (rom_load_req && !rom_load_valid &&
                 wait_cnt == delay_cyc) begin
      wait_cnt       <= 4'h0;
      rom_load_valid <= 1'b1;
      rom_id_upper   <= word_upper;
      rom_id_lower   <= word_lower;
    end else begin
      wait_cnt       <= rom_load_req ? wait_cnt + 4'h1 : 4'h0;
      rom_load_valid <= 1'b0;
      rom_id_upper   <= ~rom_id_upper;
      rom_id_lower   <= ~rom_id_lower;
    end
  end
endmodule : nidrm_rom_model
`default_nettype wire

// File: sim/node_id_rom_map_write_error_regs_bench.sv
// testbench: id words, rom mapping, write-error capture and interrupt
`timescale 1ns/1ps
`default_nettype none
module node_id_rom_map_write_error_regs_bench
  import nidrm_pkg::*;
;
  logic        core_clk, rst_n, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        bus_rst, rom_present, load_req, load_valid, pw_error;
  logic        rom_rd_valid, host_rd_valid, id_locked, irq;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb, dly;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] wdata, rdata, host_rd_addr, rom_up, rom_lo, word_up;
  logic [31:0] word_lo, id_up, id_lo, base, got, v, w;
  logic [47:0] rom_rd_offset, pw_offset, off;
  logic [15:0] pw_source, src;
  integer      seed, n_errors, total_checks;

  nidrm_regs i_nidrm_regs (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_reset_pulse(bus_rst),
    .rom_present(rom_present), .rom_load_req(load_req),
    .rom_load_valid(load_valid), .rom_id_upper(rom_up),
    .rom_id_lower(rom_lo), .rom_rd_valid(rom_rd_valid),
    .rom_rd_offset(rom_rd_offset), .host_rd_valid(host_rd_valid),
    .host_rd_addr(host_rd_addr), .pw_error(pw_error),
    .pw_offset(pw_offset), .pw_source(pw_source),
    .id_locked(id_locked), .irq(irq)
  );

  nidrm_rom_model i_nidrm_rom_model (
    .core_clk(core_clk), .rst_n(rst_n), .rom_load_req(load_req),
    .delay_cyc(dly), .word_upper(word_up), .word_lower(word_lo),
    .rom_load_valid(load_valid), .rom_id_upper(rom_up),
    .rom_id_lower(rom_lo)
  );

  // ------------------------------------------------------------------
  // clock, checks and bus tasks
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_resp

  task automatic chk_flag(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_flag

  function automatic logic [31:0] exp_map(input logic [31:0] b,
                                          input logic [9:0] o);
    return (b & ROM_MAP_FIELD_MASK) + {22'h00_0000, o};
  endfunction : exp_map

  function automatic logic [31:0] exp_err_hi(input logic [15:0] s,
                                             input logic [47:0] o);
    return {s, o[47:32]};
  endfunction : exp_err_hi

  // sampled at the falling edge: inputs only move just after rising edges
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_go, w_go, b_go;
    b_go = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    while (!b_go) begin
      @(negedge core_clk);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = (bvalid === 1'b1);
      resp  = bresp;
      @(posedge core_clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    chk_resp(er, resp);
  endtask : wr_chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic ar_go, r_go;
    r_go = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    while (!r_go) begin
      @(negedge core_clk);
      ar_go = arvalid && arready;
      r_go  = (rvalid === 1'b1);
      got   = rdata;
      resp  = rresp;
      @(posedge core_clk);
      if (ar_go) arvalid <= 1'b0;
    end
    chk_word(e, got);
    chk_resp(er, resp);
  endtask : rd_chk

  task automatic probe(input logic [47:0] o, input logic ev,
                       input logic [31:0] ea);
    rom_rd_valid  <= 1'b1;
    rom_rd_offset <= o;
    @(posedge core_clk);
    rom_rd_valid <= 1'b0;
    @(negedge core_clk);
    chk_flag(ev, host_rd_valid);
    if (ev) chk_word(ea, host_rd_addr);
    @(posedge core_clk);
  endtask : probe

  // waits for the lock with a bound; without a rom the bound simply expires
  task automatic bus_reset(input logic p);
    bus_rst     <= 1'b1;
    rom_present <= p;
    @(posedge core_clk);
    bus_rst <= 1'b0;
    for (int i = 0; i < 24 && id_locked !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
  endtask : bus_reset

  task automatic irq_is(input logic e);
    @(negedge core_clk);
    chk_flag(e, irq);
    @(posedge core_clk);
  endtask : irq_is

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    close_out();
  end

  initial begin
    {seed, n_errors, total_checks} = {32'd717, 32'd0, 32'd0};
    // bready and rready stay high: answers are taken the edge they show
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h05;
    {bus_rst, rom_present, rom_rd_valid, pw_error} = 4'h0;
    {awaddr, araddr, wdata, wstrb, dly} = 56'h0f0;
    {word_up, word_lo, rom_rd_offset, pw_offset, pw_source} = '0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(UNIQUE_ID_UPPER_OFS, UNIQUE_ID_RESET, AXI_OKAY);
    rd_chk(UNIQUE_ID_LOWER_OFS, UNIQUE_ID_RESET, AXI_OKAY);
    rd_chk(ROM_MAP_BASE_OFS, ROM_MAP_RESET, AXI_OKAY);
    rd_chk(8'h40, 32'h0, AXI_SLVERR);
    wr_chk(8'h40, 32'hffff_ffff, AXI_SLVERR);
    // map writes: all ones first, then random; each followed by a lookup
    for (int i = 0; i < 6; i++) begin
      base = (i == 0) ? 32'hffff_ffff : $random(seed);
      v = $random(seed);
      wr_chk(ROM_MAP_BASE_OFS, base, AXI_OKAY);
      rd_chk(ROM_MAP_BASE_OFS, base & ROM_MAP_FIELD_MASK, AXI_OKAY);
      probe({ROM_SPACE_FIRST[47:10], v[9:0]}, 1'b1,
            exp_map(base, v[9:0]));
    end
    probe(ROM_SPACE_FIRST - 48'h1, 1'b0, 32'h0);
    probe(ROM_SPACE_LAST + 48'h1, 1'b0, 32'h0);
    probe(ROM_SPACE_LAST, 1'b1, exp_map(base, 10'h3ff));
    id_up = $random(seed);
    id_lo = $random(seed);
    word_up <= id_up;
    word_lo <= id_lo;
    dly     <= 4'h7;
    bus_reset(1'b0);
    chk_flag(1'b0, id_locked);
    wr_chk(UNIQUE_ID_LOWER_OFS, id_lo, AXI_OKAY);
    rd_chk(UNIQUE_ID_LOWER_OFS, 32'h0, AXI_OKAY);
    bus_reset(1'b1);
    chk_flag(1'b1, id_locked);
    rd_chk(UNIQUE_ID_UPPER_OFS, id_up, AXI_OKAY);
    rd_chk(UNIQUE_ID_LOWER_OFS, id_lo, AXI_OKAY);
    word_up <= ~id_up;
    word_lo <= ~id_lo;
    dly     <= 4'h0;
    bus_reset(1'b1);
    wr_chk(UNIQUE_ID_UPPER_OFS, ~id_up, AXI_OKAY);
    rd_chk(UNIQUE_ID_UPPER_OFS, id_up, AXI_OKAY);
    rd_chk(UNIQUE_ID_LOWER_OFS, id_lo, AXI_OKAY);
    // back-to-back write failures in pairs, the later one must win
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      w = $random(seed);
      src = v[31:16];
      off = {v[15:0], w};
      pw_error  <= 1'b1;
      pw_offset <= off;
      pw_source <= src;
      @(posedge core_clk);
      if (i % 2 == 1) begin
        pw_error <= 1'b0;
        rd_chk(WRITE_ERROR_ADDR_LOW_OFS, off[31:0], AXI_OKAY);
        rd_chk(WRITE_ERROR_ADDR_HIGH_OFS, exp_err_hi(src, off),
               AXI_OKAY);
      end
    end
    wr_chk(WRITE_ERROR_ADDR_LOW_OFS, ~off[31:0], AXI_OKAY);
    rd_chk(WRITE_ERROR_ADDR_LOW_OFS, off[31:0], AXI_OKAY);
    wr_chk(WRITE_ERROR_ADDR_HIGH_OFS, ~v, AXI_OKAY);
    rd_chk(WRITE_ERROR_ADDR_HIGH_OFS, exp_err_hi(src, off), AXI_OKAY);
    rd_chk(IRQ_STATUS_OFS, 32'h3, AXI_OKAY);
    irq_is(1'b0);
    wr_chk(IRQ_MASK_OFS, 32'h2, AXI_OKAY);
    irq_is(1'b1);
    wr_chk(IRQ_STATUS_OFS, 32'h1, AXI_OKAY);
    rd_chk(IRQ_STATUS_OFS, 32'h2, AXI_OKAY);
    irq_is(1'b1);
    wr_chk(IRQ_STATUS_OFS, 32'h2, AXI_OKAY);
    irq_is(1'b0);
    // second hardware reset in mid-run, then a prompt rom answer
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk_flag(1'b0, id_locked);
    rd_chk(UNIQUE_ID_UPPER_OFS, UNIQUE_ID_RESET, AXI_OKAY);
    bus_reset(1'b1);
    rd_chk(UNIQUE_ID_UPPER_OFS, ~id_up, AXI_OKAY);
    rd_chk(UNIQUE_ID_LOWER_OFS, ~id_lo, AXI_OKAY);
    close_out();
  end
endmodule : node_id_rom_map_write_error_regs_bench
`default_nettype wire
